// file: spmc_power_mode.v
// Sleep and idle power-mode controller with AHB-Lite register slave
// Overview of operation
// - Sleep instruction with idle-select clear enters full Sleep.
// - Sleep entry clears watchdog; watchdog keeps running if enabled for Sleep.
// - Sleep entry clears power-down flag and sets timeout flag.
// - Processor clock gated in Sleep; internal and secondary oscillators untouched.
// - Only Sleep removes system clock and its divide-by-four clock.
// - I/O ports hold their drive state throughout Sleep.
// - Sleep changes no reset source except the watchdog one.
// - Reset sources cause full reset; interrupts except clock switch resume.
// - Interrupt wakes if enabled and peripheral gate set outside first bank.
// - Next instruction prefetched at entry; vector after it only if global gate.
// - Every wake from Sleep clears the watchdog counter.
// - Execution resumes from Sleep only when flash, oscillator and, if enabled, brown-out are ready.
// - Enabled flag pending at sleep instruction makes it a no-operation.
// - Flag set during or after entry completes Sleep then wakes at once.
// - Regulator low-power select picks low-power Sleep, else normal regulator.
// - Wake from low-power Sleep adds a stabilisation delay.
// - Idle-select set makes sleep instruction enter Idle, halting core and flash.
// - Any interrupt except clock switch ends Idle regardless of global gate; idle-select unchanged.
// - Recover-on-interrupt with reduced rate restores full speed on an interrupt exit from Idle.
// - Watchdog in Idle wakes instead of resetting; reduced rate unchanged.
// - Selected clocks and peripherals stay active in Idle and reduced rate.
// - Clock output keeps toggling in Idle when its active-low enable is 0.
// - Regulator select 1 means low-power Sleep, 0 means normal power.
// - With recover-on-interrupt, interrupt entry clears reduced-rate enable.
`timescale 1ns/1ps
`include "spmc_defs.vh"

module spmc_sync #(
    parameter WIDTH = 1
) (
    input wire clk,
    input wire rst,
    input wire [WIDTH-1:0] async_in,
    input wire [WIDTH-1:0] rst_val,
    output reg [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] s1;
    reg [WIDTH-1:0] s2;
    reg [WIDTH-1:0] s3;
    integer i;

    // Stages reset to the idle level to avoid a false edge; stages two and three must agree
    always @(posedge clk) begin
        if (rst) begin
            s1 <= rst_val;
            s2 <= rst_val;
            s3 <= rst_val;
            sync_out <= rst_val;
        end else begin
            s1 <= async_in;
            s2 <= s1;
            s3 <= s2;
            for (i = 0; i < WIDTH; i = i + 1) begin
                if (s2[i] == s3[i]) begin
                    sync_out[i] <= s3[i];
                end
            end
        end
    end
endmodule

module spmc_power_mode #(
    parameter IRQ_N = 16,
    parameter LP_WAKE_CYC = `SPMC_LP_WAKE_CYC
) (
    input wire REF_CLK_I,
    input wire SRST_I,
    input wire HSEL_I,
    input wire [31:0] HADDR_I,
    input wire [1:0] HTRANS_I,
    input wire HWRITE_I,
    input wire [2:0] HSIZE_I,
    input wire [31:0] HWDATA_I,
    input wire HREADY_I,
    output reg [31:0] HRDATA_O,
    output wire HREADYOUT_O,
    output wire HRESP_O,
    input wire SLEEP_EXEC_I,
    input wire IRQ_ENTRY_I,
    input wire [IRQ_N-1:0] IRQ_FLAG_I,
    input wire [IRQ_N-1:0] IRQ_ENABLE_I,
    input wire [IRQ_N-1:0] IRQ_FIRST_BANK_I,
    input wire [IRQ_N-1:0] IRQ_CLK_SWITCH_I,
    input wire PERIPHERAL_IRQ_GATE_I,
    input wire GLOBAL_IRQ_GATE_I,
    input wire WDT_EVENT_I,
    input wire EXTERNAL_RESET_PIN_N_I,
    input wire BROWNOUT_RESET_I,
    input wire LOW_POWER_BROWNOUT_RESET_I,
    input wire POWER_ON_RESET_I,
    input wire PROGRAM_FLASH_READY_I,
    input wire CURRENT_OSC_READY_I,
    input wire BROWNOUT_READY_I,
    input wire BROWNOUT_ENABLE_I,
    input wire CLOCK_OUT_ENABLE_N_I,
    output reg SYSTEM_RESET_O,
    output reg WDT_CLEAR_O,
    output reg PREFETCH_NEXT_O,
    output reg EXEC_RESUME_O,
    output reg VECTOR_AFTER_NEXT_O,
    output reg CPU_CLK_EN_O,
    output reg PROGRAM_FLASH_EN_O,
    output reg SYS_CLK_EN_O,
    output reg IO_HOLD_O,
    output reg REGULATOR_LOW_POWER_O,
    output wire PERIPH_CLK_EN_O,
    output wire OSC_KEEP_O,
    output reg CLOCK_OUT_RUN_O,
    output wire REDUCED_RATE_ENABLE_O,
    output wire [2:0] MODE_O
);
    localparam CNT_W = 16;

    // Synchronised pin-level inputs; external reset pin is active low
    wire [7:0] pin_sync;
    wire ext_reset_n;
    wire bor_evt;
    wire low_power_brownout_reset_evt;
    wire por_evt;
    wire flash_ready;
    wire osc_ready;
    wire bor_ready;
    wire bor_en;

    spmc_sync #(
        .WIDTH(8)
    ) u_sync (
        .clk(REF_CLK_I),
        .rst(SRST_I),
        .async_in({BROWNOUT_ENABLE_I, BROWNOUT_READY_I, CURRENT_OSC_READY_I,
            PROGRAM_FLASH_READY_I, POWER_ON_RESET_I, LOW_POWER_BROWNOUT_RESET_I,
            BROWNOUT_RESET_I, EXTERNAL_RESET_PIN_N_I}),
        .rst_val(8'h01),
        .sync_out(pin_sync)
    );

    assign ext_reset_n = pin_sync[0];
    assign bor_evt = pin_sync[1];
    assign low_power_brownout_reset_evt = pin_sync[2];
    assign por_evt = pin_sync[3];
    assign flash_ready = pin_sync[4];
    assign osc_ready = pin_sync[5];
    assign bor_ready = pin_sync[6];
    assign bor_en = pin_sync[7];

    reg [2:0] state;
    reg [2:0] next_state;
    reg sleep_selects_idle;
    reg reduced_rate_enable;
    reg recover_on_irq;
    reg regulator_low_power_select;
    reg power_down_flag;
    reg timeout_flag;
    reg [1:0] wake_cause;
    reg wake_low_power;
    reg [CNT_W-1:0] lp_count;

    // AHB-Lite data-phase capture
    reg dp_write;
    reg dp_read;
    reg [7:0] dp_addr;

    wire ahb_go;
    wire [IRQ_N-1:0] irq_live;
    wire wake_irq;
    wire reset_evt;
    wire ready_all;
    wire lp_done;
    wire commit_sleep;
    wire ctrl_wr;

    assign HREADYOUT_O = 1'b1;
    assign HRESP_O = 1'b0;
    assign ahb_go = HSEL_I & HREADY_I & (HTRANS_I == `SPMC_HTRANS_NONSEQ ||
        HTRANS_I == `SPMC_HTRANS_SEQ);
    assign ctrl_wr = dp_write && dp_addr == `SPMC_CTRL_OFS;

    // Interrupt qualifies when enabled; outside the first bank it also needs
    // the peripheral gate; the global gate plays no part; clock switch never wakes
    assign irq_live = IRQ_FLAG_I & IRQ_ENABLE_I & ~IRQ_CLK_SWITCH_I &
        (IRQ_FIRST_BANK_I | {IRQ_N{PERIPHERAL_IRQ_GATE_I}});
    assign wake_irq = |irq_live;

    // Brown-out, low-power brown-out, power-on and external reset act
    // identically in every state
    assign reset_evt = ~ext_reset_n | bor_evt | low_power_brownout_reset_evt | por_evt;

    assign ready_all = flash_ready & osc_ready & (bor_ready | ~bor_en);
    assign lp_done = ~wake_low_power || lp_count == {CNT_W{1'b0}};

    // Pending flags are looked at in the same cycle as the commit strobe
    assign commit_sleep = SLEEP_EXEC_I & ~wake_irq;

    assign REDUCED_RATE_ENABLE_O = reduced_rate_enable;
    assign MODE_O = state;
    assign PERIPH_CLK_EN_O = 1'b1;
    // Internal, secondary and converter oscillators are never stopped here
    assign OSC_KEEP_O = 1'b1;

    always @* begin
        next_state = state;
        case (state)
            `SPMC_ST_RUN: begin
                if (commit_sleep) begin
                    if (sleep_selects_idle) begin
                        next_state = `SPMC_ST_IDLE;
                    end else begin
                        next_state = `SPMC_ST_SLEEP;
                    end
                end
            end
            `SPMC_ST_IDLE: begin
                if (wake_irq || WDT_EVENT_I) begin
                    next_state = `SPMC_ST_RUN;
                end
            end
            `SPMC_ST_SLEEP: begin
                if (wake_irq) begin
                    next_state = `SPMC_ST_WAKE;
                end
            end
            `SPMC_ST_WAKE: begin
                if (ready_all && lp_done) begin
                    next_state = `SPMC_ST_RUN;
                end
            end
            default: begin
                next_state = `SPMC_ST_RUN;
            end
        endcase
        // Watchdog resets from run, Sleep and the ready wait; in Idle it only wakes
        if (reset_evt || (WDT_EVENT_I && state != `SPMC_ST_IDLE)) begin
            next_state = `SPMC_ST_RUN;
        end
    end

    always @(posedge REF_CLK_I) begin
        if (SRST_I) begin
            state <= `SPMC_ST_RUN;
        end else begin
            state <= next_state;
        end
    end

    // Status flags: set at power-up, updated only by a committed Sleep entry
    always @(posedge REF_CLK_I) begin
        if (SRST_I) begin
            power_down_flag <= 1'b1;
            timeout_flag <= 1'b1;
        end else if (state == `SPMC_ST_RUN && commit_sleep && !sleep_selects_idle &&
                !reset_evt && !WDT_EVENT_I) begin
            power_down_flag <= 1'b0;
            timeout_flag <= 1'b1;
        end
    end

    // Low-power wake delay, loaded at Sleep entry from the regulator choice
    always @(posedge REF_CLK_I) begin
        if (SRST_I) begin
            wake_low_power <= 1'b0;
            lp_count <= {CNT_W{1'b0}};
            wake_cause <= `SPMC_WK_NONE;
        end else begin
            if (state == `SPMC_ST_RUN && next_state == `SPMC_ST_SLEEP) begin
                wake_low_power <= regulator_low_power_select;
                lp_count <= LP_WAKE_CYC[CNT_W-1:0];
                wake_cause <= `SPMC_WK_NONE;
            end else if (state == `SPMC_ST_SLEEP && next_state == `SPMC_ST_WAKE) begin
                wake_cause <= `SPMC_WK_IRQ;
            end else if (state == `SPMC_ST_WAKE && lp_count != {CNT_W{1'b0}}) begin
                lp_count <= lp_count - {{(CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end

    // Control register; hardware clears reduced-rate on interrupt recovery
    always @(posedge REF_CLK_I) begin
        if (SRST_I) begin
            sleep_selects_idle <= 1'b0;
            reduced_rate_enable <= 1'b0;
            recover_on_irq <= 1'b0;
            regulator_low_power_select <= 1'b0;
        end else begin
            if (recover_on_irq && reduced_rate_enable) begin
                if (IRQ_ENTRY_I) begin
                    reduced_rate_enable <= 1'b0;
                end
                if (state == `SPMC_ST_IDLE && wake_irq) begin
                    reduced_rate_enable <= 1'b0;
                end
            end
            // Idle-select is never touched by hardware, so Idle can be re-entered
            if (ctrl_wr) begin
                sleep_selects_idle <= HWDATA_I[`SPMC_CTRL_IDLE_BIT];
                reduced_rate_enable <= HWDATA_I[`SPMC_CTRL_RATE_BIT];
                recover_on_irq <= HWDATA_I[`SPMC_CTRL_ROI_BIT];
                regulator_low_power_select <= HWDATA_I[`SPMC_CTRL_LPSEL_BIT];
            end
        end
    end

    // Bus slave: zero wait states, unmapped addresses read zero and ignore writes
    always @(posedge REF_CLK_I) begin
        if (SRST_I) begin
            dp_write <= 1'b0;
            dp_read <= 1'b0;
            dp_addr <= 8'h00;
        end else begin
            dp_write <= ahb_go & HWRITE_I;
            dp_read <= ahb_go & ~HWRITE_I;
            dp_addr <= HADDR_I[7:0];
        end
    end

    always @* begin
        HRDATA_O = 32'h00000000;
        if (dp_read) begin
            if (dp_addr == `SPMC_CTRL_OFS) begin
                HRDATA_O[`SPMC_CTRL_IDLE_BIT] = sleep_selects_idle;
                HRDATA_O[`SPMC_CTRL_RATE_BIT] = reduced_rate_enable;
                HRDATA_O[`SPMC_CTRL_ROI_BIT] = recover_on_irq;
                HRDATA_O[`SPMC_CTRL_LPSEL_BIT] = regulator_low_power_select;
            end else if (dp_addr == `SPMC_STATUS_OFS) begin
                HRDATA_O[`SPMC_STAT_PD_BIT] = power_down_flag;
                HRDATA_O[`SPMC_STAT_TO_BIT] = timeout_flag;
                HRDATA_O[`SPMC_STAT_STATE_LSB+2:`SPMC_STAT_STATE_LSB] = state;
            end
        end
    end

    // Pulses and clock controls, all registered
    always @(posedge REF_CLK_I) begin
        if (SRST_I) begin
            SYSTEM_RESET_O <= 1'b0;
            WDT_CLEAR_O <= 1'b0;
            PREFETCH_NEXT_O <= 1'b0;
            EXEC_RESUME_O <= 1'b0;
            VECTOR_AFTER_NEXT_O <= 1'b0;
            CPU_CLK_EN_O <= 1'b1;
            PROGRAM_FLASH_EN_O <= 1'b1;
            SYS_CLK_EN_O <= 1'b1;
            IO_HOLD_O <= 1'b0;
            REGULATOR_LOW_POWER_O <= 1'b0;
            CLOCK_OUT_RUN_O <= 1'b0;
        end else begin
            SYSTEM_RESET_O <= reset_evt | (WDT_EVENT_I & (state != `SPMC_ST_IDLE));
            // Watchdog cleared on Sleep entry and on every wake out of Sleep
            WDT_CLEAR_O <= (state == `SPMC_ST_RUN && next_state == `SPMC_ST_SLEEP) ||
                (state == `SPMC_ST_SLEEP && next_state != `SPMC_ST_SLEEP);
            PREFETCH_NEXT_O <= state == `SPMC_ST_RUN && commit_sleep;
            // Resume after an interrupt wake or an Idle watchdog wake; vector follows only with global gate
            EXEC_RESUME_O <= (state == `SPMC_ST_WAKE && next_state == `SPMC_ST_RUN) ||
                (state == `SPMC_ST_IDLE && next_state == `SPMC_ST_RUN && !reset_evt);
            VECTOR_AFTER_NEXT_O <= GLOBAL_IRQ_GATE_I && !reset_evt &&
                ((state == `SPMC_ST_WAKE && next_state == `SPMC_ST_RUN &&
                wake_cause == `SPMC_WK_IRQ) ||
                (state == `SPMC_ST_IDLE && wake_irq));
            // Core and flash stop in Idle and Sleep; system clocks only in Sleep
            CPU_CLK_EN_O <= next_state == `SPMC_ST_RUN;
            PROGRAM_FLASH_EN_O <= next_state == `SPMC_ST_RUN;
            SYS_CLK_EN_O <= next_state != `SPMC_ST_SLEEP;
            // Ports freeze through Sleep and the ready wait that ends it
            IO_HOLD_O <= next_state == `SPMC_ST_SLEEP || next_state == `SPMC_ST_WAKE;
            REGULATOR_LOW_POWER_O <= next_state == `SPMC_ST_SLEEP &&
                (state == `SPMC_ST_SLEEP ? wake_low_power : regulator_low_power_select);
            // Clock output runs in run and Idle when enabled, and stops in Sleep and the ready wait
            CLOCK_OUT_RUN_O <= !CLOCK_OUT_ENABLE_N_I && next_state != `SPMC_ST_SLEEP &&
                next_state != `SPMC_ST_WAKE;
        end
    end
endmodule

// file: spmc_defs.vh
// Constants for the sleep and idle power-mode controller
`ifndef SPMC_DEFS_VH
`define SPMC_DEFS_VH

// Register byte offsets on the bus
`define SPMC_CTRL_OFS 8'h00
`define SPMC_STATUS_OFS 8'h04

// Control register fields
`define SPMC_CTRL_IDLE_BIT 0
`define SPMC_CTRL_RATE_BIT 1
`define SPMC_CTRL_ROI_BIT 2
`define SPMC_CTRL_LPSEL_BIT 3
`define SPMC_CTRL_RESET 4'h0

// Status register fields
`define SPMC_STAT_PD_BIT 0
`define SPMC_STAT_TO_BIT 1
`define SPMC_STAT_STATE_LSB 2

// Controller states
`define SPMC_ST_RUN 3'h0
`define SPMC_ST_IDLE 3'h1
`define SPMC_ST_SLEEP 3'h2
`define SPMC_ST_WAKE 3'h3

// Cause of the wake held during the ready wait
`define SPMC_WK_IRQ 2'h0
`define SPMC_WK_WDT 2'h1
`define SPMC_WK_NONE 2'h2

// Timing
`define SPMC_CLK_PERIOD_PS 25000
`define SPMC_LP_WAKE_NS 10000
`define SPMC_LP_WAKE_CYC ((`SPMC_LP_WAKE_NS * 1000 + `SPMC_CLK_PERIOD_PS - 1) / `SPMC_CLK_PERIOD_PS)

// AHB encodings
`define SPMC_HTRANS_NONSEQ 2'h2
`define SPMC_HTRANS_SEQ 2'h3

`endif

// file: spmc_core_model.sv
// Core model: commits sleep instructions and enters the interrupt routine
`timescale 1ns/1ps
module spmc_core_model (
    input wire clk_i,
    input wire rst_i,
    input wire sleep_req_i,
    input wire vector_i,
    output reg sleep_exec_o,
    output reg irq_entry_o
);
    reg seen;
    // Each toggle of the request commits exactly one single-cycle sleep instruction
    always @(posedge clk_i) begin
        if (rst_i) begin
            sleep_exec_o <= 1'b0;
            irq_entry_o <= 1'b0;
            seen <= 1'b0;
        end else begin
            seen <= sleep_req_i;
            sleep_exec_o <= sleep_req_i ^ seen;
            // Prefetched instruction runs first, so the routine is entered a cycle later
            irq_entry_o <= vector_i;
        end
    end
endmodule

// file: spmc_power_mode_chk.sv
// Concurrent checks on the power-mode controller ports
`timescale 1ns/1ps
`include "spmc_defs.vh"
module spmc_power_mode_chk #(
    parameter IRQ_N = 16
) (
    input wire REF_CLK_I,
    input wire SRST_I,
    input wire SLEEP_EXEC_I,
    input wire [IRQ_N-1:0] IRQ_FLAG_I,
    input wire [IRQ_N-1:0] IRQ_ENABLE_I,
    input wire [IRQ_N-1:0] IRQ_FIRST_BANK_I,
    input wire [IRQ_N-1:0] IRQ_CLK_SWITCH_I,
    input wire PERIPHERAL_IRQ_GATE_I,
    input wire GLOBAL_IRQ_GATE_I,
    input wire WDT_EVENT_I,
    input wire SYSTEM_RESET_O,
    input wire WDT_CLEAR_O,
    input wire PREFETCH_NEXT_O,
    input wire EXEC_RESUME_O,
    input wire VECTOR_AFTER_NEXT_O,
    input wire CPU_CLK_EN_O,
    input wire PROGRAM_FLASH_EN_O,
    input wire PERIPH_CLK_EN_O,
    input wire OSC_KEEP_O,
    input wire SYS_CLK_EN_O,
    input wire IO_HOLD_O,
    input wire REGULATOR_LOW_POWER_O,
    input wire [2:0] MODE_O
);
    wire [IRQ_N-1:0] qual = IRQ_FLAG_I & IRQ_ENABLE_I & ~IRQ_CLK_SWITCH_I &
        (IRQ_FIRST_BANK_I | {IRQ_N{PERIPHERAL_IRQ_GATE_I}});
    wire pend = |qual;
    wire run = MODE_O == `SPMC_ST_RUN;
    default clocking cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (SRST_I);
    sequence run_then_sleep;
        run ##1 MODE_O == `SPMC_ST_SLEEP;
    endsequence
    sequence sleep_then_wake;
        MODE_O == `SPMC_ST_SLEEP ##1 MODE_O == `SPMC_ST_WAKE;
    endsequence
    sleep_entry_a: assert property (SLEEP_EXEC_I && run && !pend && !WDT_EVENT_I
        |=> !run && PREFETCH_NEXT_O) else $error("sleep entry missed");
    sleep_nop_a: assert property (SLEEP_EXEC_I && run && pend
        |=> run && !WDT_CLEAR_O && !PREFETCH_NEXT_O) else $error("pending sleep not a nop");
    sleep_clocks_a: assert property (MODE_O == `SPMC_ST_SLEEP
        |-> !CPU_CLK_EN_O && !SYS_CLK_EN_O && IO_HOLD_O && !PROGRAM_FLASH_EN_O && OSC_KEEP_O)
        else $error("sleep gating wrong");
    idle_clocks_a: assert property (MODE_O == `SPMC_ST_IDLE
        |-> !CPU_CLK_EN_O && SYS_CLK_EN_O && !PROGRAM_FLASH_EN_O && PERIPH_CLK_EN_O)
        else $error("idle gating wrong");
    entry_clear_a: assert property (run_then_sleep |-> WDT_CLEAR_O)
        else $error("no watchdog clear on entry");
    wake_clear_a: assert property (sleep_then_wake |-> WDT_CLEAR_O)
        else $error("no watchdog clear on wake");
    lp_delay_a: assert property ($fell(REGULATOR_LOW_POWER_O) && MODE_O == `SPMC_ST_WAKE
        |-> (MODE_O == `SPMC_ST_WAKE) [*3]) else $error("low-power wake too fast");
    idle_wdt_a: assert property (MODE_O == `SPMC_ST_IDLE && WDT_EVENT_I
        |=> run && !VECTOR_AFTER_NEXT_O ##1 !SYSTEM_RESET_O) else $error("idle watchdog");
    vector_gate_a: assert property (VECTOR_AFTER_NEXT_O
        |-> EXEC_RESUME_O && $past(GLOBAL_IRQ_GATE_I)) else $error("vector without gate");
    lp_sleep_only_a: assert property (MODE_O != `SPMC_ST_SLEEP |-> !REGULATOR_LOW_POWER_O)
        else $error("low-power regulator outside sleep");
endmodule
bind spmc_power_mode spmc_power_mode_chk #(.IRQ_N(IRQ_N)) spmc_power_mode_chk_inst (
    .REF_CLK_I(REF_CLK_I), .SRST_I(SRST_I), .SLEEP_EXEC_I(SLEEP_EXEC_I),
    .IRQ_FLAG_I(IRQ_FLAG_I), .IRQ_ENABLE_I(IRQ_ENABLE_I), .IRQ_FIRST_BANK_I(IRQ_FIRST_BANK_I),
    .IRQ_CLK_SWITCH_I(IRQ_CLK_SWITCH_I), .PERIPHERAL_IRQ_GATE_I(PERIPHERAL_IRQ_GATE_I),
    .GLOBAL_IRQ_GATE_I(GLOBAL_IRQ_GATE_I), .WDT_EVENT_I(WDT_EVENT_I),
    .SYSTEM_RESET_O(SYSTEM_RESET_O), .WDT_CLEAR_O(WDT_CLEAR_O),
    .PREFETCH_NEXT_O(PREFETCH_NEXT_O), .EXEC_RESUME_O(EXEC_RESUME_O),
    .VECTOR_AFTER_NEXT_O(VECTOR_AFTER_NEXT_O), .CPU_CLK_EN_O(CPU_CLK_EN_O),
    .PROGRAM_FLASH_EN_O(PROGRAM_FLASH_EN_O), .PERIPH_CLK_EN_O(PERIPH_CLK_EN_O),
    .OSC_KEEP_O(OSC_KEEP_O),
    .SYS_CLK_EN_O(SYS_CLK_EN_O), .IO_HOLD_O(IO_HOLD_O),
    .REGULATOR_LOW_POWER_O(REGULATOR_LOW_POWER_O), .MODE_O(MODE_O));

// file: sleep_idle_power_mode_control_test.sv
// Testbench for the sleep and idle power-mode controller
`timescale 1ns/1ps
`include "spmc_defs.vh"
module sleep_idle_power_mode_control_test;
    localparam LPC = 4;
    reg clk = 0, srst = 1, hwrite = 0, sleep_req = 0, peripheral_irq_gate = 0, global_irq_gate = 0, wdt = 0, bor_en = 1;
    reg [1:0] htrans = 2'h0;
    reg [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
    reg [3:0] flag = 4'h0, src = 4'h0, en = 4'hb;
    reg [2:0] rdy = 3'h7;
    reg clkout_n = 0;
    wire hready, sleep_exec, irq_entry, sys_rst, resume, vec, red_rate, clkout, lp;
    wire [2:0] mode;
    wire [31:0] hrdata;
    integer errors = 0, checked = 0, n0, n1, i;
    spmc_power_mode #(.IRQ_N(4), .LP_WAKE_CYC(LPC)) spmc_power_mode_inst (
        .REF_CLK_I(clk), .SRST_I(srst), .HSEL_I(1'b1), .HADDR_I(haddr), .HTRANS_I(htrans),
        .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready),
        .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(), .SLEEP_EXEC_I(sleep_exec),
        .IRQ_ENTRY_I(irq_entry), .IRQ_FLAG_I(flag), .IRQ_ENABLE_I(en),
        .IRQ_FIRST_BANK_I(4'h1), .IRQ_CLK_SWITCH_I(4'h8), .PERIPHERAL_IRQ_GATE_I(peripheral_irq_gate),
        .GLOBAL_IRQ_GATE_I(global_irq_gate), .WDT_EVENT_I(wdt), .EXTERNAL_RESET_PIN_N_I(~src[0]),
        .BROWNOUT_RESET_I(src[1]), .LOW_POWER_BROWNOUT_RESET_I(src[2]),
        .POWER_ON_RESET_I(src[3]), .PROGRAM_FLASH_READY_I(rdy[0]),
        .CURRENT_OSC_READY_I(rdy[1]), .BROWNOUT_READY_I(rdy[2]), .BROWNOUT_ENABLE_I(bor_en),
        .CLOCK_OUT_ENABLE_N_I(clkout_n), .SYSTEM_RESET_O(sys_rst), .WDT_CLEAR_O(),
        .PREFETCH_NEXT_O(), .EXEC_RESUME_O(resume), .VECTOR_AFTER_NEXT_O(vec),
        .CPU_CLK_EN_O(), .PROGRAM_FLASH_EN_O(), .SYS_CLK_EN_O(), .IO_HOLD_O(),
        .REGULATOR_LOW_POWER_O(lp), .PERIPH_CLK_EN_O(), .OSC_KEEP_O(),
        .CLOCK_OUT_RUN_O(clkout), .REDUCED_RATE_ENABLE_O(red_rate), .MODE_O(mode));
    spmc_core_model spmc_core_model_inst (.clk_i(clk), .rst_i(srst), .sleep_req_i(sleep_req),
        .vector_i(vec), .sleep_exec_o(sleep_exec), .irq_entry_o(irq_entry));
    initial begin
        forever #12.5 clk = ~clk;
    end
    task chk(input [31:0] got, input [31:0] exp);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                errors = errors + 1;
                $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task cyc(input integer n);
        begin
            repeat (n) @(posedge clk);
        end
    endtask
    task bus(input w, input [31:0] a, input [31:0] d);
        begin
            htrans <= `SPMC_HTRANS_NONSEQ;
            haddr <= a;
            hwrite <= w;
            @(posedge clk);
            while (hready !== 1'b1) @(posedge clk);
            htrans <= 2'h0;
            hwdata <= d;
            @(posedge clk);
            while (hready !== 1'b1) @(posedge clk);
            rd = hrdata;
        end
    endtask
    task sleep_go;
        begin
            sleep_req <= ~sleep_req;
            cyc(3);
        end
    endtask
    // Unbounded here; the 5000-cycle time limit still ends the run if a wake never comes
    task wake(output integer n);
        begin
            n = 0;
            while (resume !== 1'b1) begin
                @(posedge clk);
                n = n + 1;
            end
        end
    endtask
    task stop_test;
        begin
            $display("Checks %0d, mismatches %0d", checked, errors);
            if (errors == 0 && checked > 0)
                $display("TEST PASSED");
            else
                $display("TEST FAILED");
            $finish;
        end
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        errors = errors + 1;
        stop_test;
    end
    initial begin
        cyc(16);
        srst <= 1'b0;
        cyc(5);
        bus(0, `SPMC_CTRL_OFS, 0);
        chk(rd, `SPMC_CTRL_RESET);
        bus(0, `SPMC_STATUS_OFS, 0);
        chk(rd, 32'h3);
        bus(1, 32'h8, 32'hf);
        bus(0, 32'h8, 0);
        chk(rd, 32'h0);
        flag <= 4'h1;
        sleep_go;
        chk(mode, `SPMC_ST_RUN);
        bus(0, `SPMC_STATUS_OFS, 0);
        chk(rd, 32'h3);
        flag <= 4'h0;
        rdy <= 3'h2;
        sleep_go;
        bus(0, `SPMC_STATUS_OFS, 0);
        chk(rd, 32'ha);
        // Gate closed, enable clear and clock-switch source: none may wake
        flag <= 4'he;
        cyc(8);
        chk(mode, `SPMC_ST_SLEEP);
        peripheral_irq_gate <= 1'b1;
        cyc(10);
        chk(mode, `SPMC_ST_WAKE);
        rdy <= 3'h3;
        cyc(10);
        chk(mode, `SPMC_ST_WAKE);
        bor_en <= 1'b0;
        wake(n0);
        chk(mode, `SPMC_ST_RUN);
        flag <= 4'h0;
        peripheral_irq_gate <= 1'b0;
        bor_en <= 1'b1;
        rdy <= 3'h7;
        cyc(6);
        sleep_go;
        flag <= 4'h1;
        wake(n0);
        flag <= 4'h0;
        bus(1, `SPMC_CTRL_OFS, 32'h8);
        sleep_go;
        chk(lp, 1'b1);
        flag <= 4'h1;
        wake(n1);
        chk(n1, n0 + LPC);
        flag <= 4'h0;
        bus(1, `SPMC_CTRL_OFS, 32'h7);
        global_irq_gate <= 1'b1;
        sleep_go;
        chk(mode, `SPMC_ST_IDLE);
        chk(clkout, 1'b1);
        clkout_n <= 1'b1;
        cyc(2);
        chk(clkout, 1'b0);
        clkout_n <= 1'b0;
        flag <= 4'h1;
        wake(n0);
        cyc(3);
        chk(red_rate, 1'b0);
        bus(0, `SPMC_CTRL_OFS, 0);
        chk(rd, 32'h5);
        // Sleep wake with vector: only interrupt entry can clear reduced rate
        flag <= 4'h0;
        bus(1, `SPMC_CTRL_OFS, 32'h6);
        sleep_go;
        chk(red_rate, 1'b1);
        flag <= 4'h1;
        wake(n0);
        cyc(2);
        chk(red_rate, 1'b0);
        flag <= 4'h0;
        global_irq_gate <= 1'b0;
        // Recover-on-interrupt set, so a kept reduced rate shows the wake is no interrupt
        bus(1, `SPMC_CTRL_OFS, 32'h7);
        sleep_go;
        wdt <= 1'b1;
        cyc(1);
        wdt <= 1'b0;
        wake(n0);
        cyc(2);
        chk(sys_rst, 1'b0);
        chk(red_rate, 1'b1);
        bus(1, `SPMC_CTRL_OFS, 32'h0);
        for (i = 0; i < 5; i = i + 1) begin
            sleep_go;
            chk(mode, `SPMC_ST_SLEEP);
            if (i < 4)
                src <= 4'h1 << i;
            else
                wdt <= 1'b1;
            cyc(7);
            chk(sys_rst, 1'b1);
            chk(mode, `SPMC_ST_RUN);
            src <= 4'h0;
            wdt <= 1'b0;
            cyc(8);
        end
        stop_test;
    end
endmodule
